// [rtl/cc_unit_pkg.sv]
// ==========================================================================
// Shared constants of the capture/compare unit
package cc_unit_pkg;
    // Byte offsets of the register map
    localparam logic [7:0] GLOBAL_CTRL_OFS = 8'h00;
    localparam logic [7:0] COUNT_VALUE_OFS = 8'h04;
    localparam logic [1:0] CH_REGION = 2'h1;       // Address bits 7:6
    localparam int CH_SEL_BIT = 2;                  // 0 control, 1 value
    // Global control fields
    localparam int GC_MODE_LO = 0;
    localparam int GC_GRP_LO = 2;
    localparam int GC_HIZ_BIT = 4;
    localparam int GC_CLR_BIT = 5;
    localparam logic [5:0] GC_RESET = 6'h00;
    // Channel control fields
    localparam int CT_FLAG_BIT = 0;
    localparam int CT_OVF_BIT = 1;
    localparam int CT_DRIVE_BIT = 2;
    localparam int CT_LEVEL_BIT = 3;
    localparam int CT_CAP_BIT = 4;
    localparam int CT_SYNC_BIT = 5;
    localparam int CT_SRC_LO = 6;
    localparam int CT_EDGE_LO = 8;
    localparam int CT_LLS_LO = 10;
    localparam int CT_OM_LO = 12;
    localparam int CT_WIDTH = 15;
    localparam logic [14:0] CT_RESET = 15'h0000;
    // Counter modes
    localparam logic [1:0] MODE_STOP = 2'h0;
    localparam logic [1:0] MODE_UP = 2'h1;
    localparam logic [1:0] MODE_CONT = 2'h2;
    localparam logic [1:0] MODE_UPDOWN = 2'h3;
    // Capture source, edge, latch load and latch group selections
    localparam logic [1:0] SRC_A = 2'h0;
    localparam logic [1:0] SRC_B = 2'h1;
    localparam logic [1:0] SRC_GND = 2'h2;
    localparam logic [1:0] SRC_VCC = 2'h3;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [1:0] LLS_WRITE = 2'h0;
    localparam logic [1:0] LLS_ZERO = 2'h1;
    localparam logic [1:0] LLS_ZERO_PER = 2'h2;
    localparam logic [1:0] LLS_OLD = 2'h3;
    localparam logic [1:0] GRP_NONE = 2'h0;
    localparam logic [1:0] GRP_PAIRS = 2'h1;
    localparam logic [1:0] GRP_TRIPLES = 2'h2;
    localparam logic [1:0] GRP_ALL = 2'h3;
endpackage

// [rtl/timer_capture_compare_unit.sv]
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module timer_capture_compare_unit #(
    parameter int NUM_CH = 7,
    parameter int CW = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [NUM_CH-1:0] channel_input_a,
    input wire logic [NUM_CH-1:0] channel_input_b,
    input wire logic output_hiz_pin,
    output logic [NUM_CH-1:0] out_level,
    output logic [NUM_CH-1:0] out_oe
);
    import cc_unit_pkg::*;

    // ======================================================================
    // Helpers
    // Controlling channel of a latch group
    function automatic logic [2:0] ctrl_of(input logic [2:0] ch,
                                           input logic [1:0] grp);
        logic [2:0] m1;
        m1 = ch - 3'h1;
        case (grp)
            GRP_PAIRS: ctrl_of = (ch == 3'h0) ? 3'h0 : {m1[2:1], 1'b1};
            GRP_TRIPLES: ctrl_of = (ch == 3'h0) ? 3'h0 :
                                   (ch <= 3'h3) ? 3'h1 : 3'h4;
            GRP_ALL: ctrl_of = 3'h1;
            default: ctrl_of = ch;
        endcase
    endfunction

    // ======================================================================
    // State
    logic waitrequest_reg, waitrequest_next;
    logic [31:0] readdata_reg, readdata_next;
    logic [5:0] gctrl_reg, gctrl_next;
    logic [CW-1:0] count_reg, count_next;
    logic dir_up_reg, dir_up_next;
    logic [CT_WIDTH-1:0] ctrl_reg [NUM_CH];
    logic [CT_WIDTH-1:0] ctrl_next [NUM_CH];
    logic [CW-1:0] value_reg [NUM_CH];
    logic [CW-1:0] value_next [NUM_CH];
    logic [CW-1:0] latch_reg [NUM_CH];
    logic [CW-1:0] latch_next [NUM_CH];
    logic [NUM_CH-1:0] pending_reg, pending_next;
    logic [NUM_CH-1:0] unread_reg, unread_next;
    logic [NUM_CH-1:0] prev_lvl_reg, prev_lvl_next;
    logic [NUM_CH-1:0] cap_dly_reg, cap_dly_next;
    logic [NUM_CH-1:0] out_reg, out_next;
    logic [NUM_CH-1:0] oe_reg, oe_next;
    logic [NUM_CH-1:0] a_s1_reg, a_s2_reg, b_s1_reg, b_s2_reg;
    logic hiz_s1_reg, hiz_s2_reg;

    logic [NUM_CH-1:0] level, match, ready;
    logic tick, zero_evt, period_evt;
    logic wr_en, rd_req, ch_hit;
    logic [2:0] ch_idx;

    // ======================================================================
    // Bus decode and counter
    // Avalon slave: one wait cycle, write taken when waitrequest is low, read taken in the wait cycle
    always_comb begin
        rd_req = avs_read & waitrequest_reg;
        wr_en = avs_write & ~waitrequest_reg;
        waitrequest_next = ~((avs_read | avs_write) & waitrequest_reg);
        ch_idx = avs_address[5:3];
        ch_hit = (avs_address[7:6] == CH_REGION) &&
                 (int'(ch_idx) < NUM_CH);
    end

    // Counter steps; the period latch is channel 0's compare latch
    always_comb begin
        logic [CW-1:0] per;
        per = latch_reg[0];
        gctrl_next = gctrl_reg;
        gctrl_next[GC_CLR_BIT] = 1'b0;
        count_next = count_reg;
        dir_up_next = dir_up_reg;
        tick = (gctrl_reg[GC_MODE_LO +: 2] != MODE_STOP);
        case (gctrl_reg[GC_MODE_LO +: 2])
            MODE_UP: count_next = (count_reg >= per) ? '0 : count_reg + 1'b1;
            MODE_CONT: count_next = count_reg + 1'b1;
            MODE_UPDOWN: begin
                if (dir_up_reg) begin
                    if (count_reg >= per) begin
                        // Reverse on reaching, or passing above, the period
                        dir_up_next = 1'b0;
                        count_next = (count_reg == '0) ? '0 :
                                     count_reg - 1'b1;
                    end else begin
                        count_next = count_reg + 1'b1;
                    end
                end else if (count_reg == '0) begin
                    // At zero turn upward again; stay at zero while the period is zero
                    dir_up_next = 1'b1;
                    count_next = (per != '0) ? {{(CW-1){1'b0}}, 1'b1} : '0;
                end else begin
                    count_next = count_reg - 1'b1;
                end
            end
            default: count_next = count_reg;
        endcase
        // Events only from counting, never from direct loads
        zero_evt = tick && count_next == '0 && count_reg != '0;
        period_evt = tick && count_next == per && count_next != count_reg;
        for (int i = 0; i < NUM_CH; i++) begin
            match[i] = tick && count_next == latch_reg[i] &&
                       count_next != count_reg;
        end
        if (wr_en && avs_address == GLOBAL_CTRL_OFS) begin
            gctrl_next = avs_writedata[5:0];
        end
        if (gctrl_next[GC_CLR_BIT]) begin
            count_next = '0;
            dir_up_next = 1'b1;
        end
        if (wr_en && avs_address == COUNT_VALUE_OFS) begin
            count_next = avs_writedata[CW-1:0];
            zero_evt = 1'b0;
            period_evt = 1'b0;
            match = '0;
        end
    end

    // ======================================================================
    // Channels
    // Capture, latch loading and output units of every channel
    always_comb begin
        logic [1:0] grp, s;
        logic [2:0] c, j;
        logic grouped, trig, cap, evt, load, wr_ctl, wr_val, hw_set;
        logic [CT_WIDTH-1:0] ct;
        grp = gctrl_reg[GC_GRP_LO +: 2];
        c = '0;
        j = '0;
        s = '0;
        grouped = 1'b0;
        trig = 1'b0;
        cap = 1'b0;
        evt = 1'b0;
        load = 1'b0;
        wr_ctl = 1'b0;
        wr_val = 1'b0;
        hw_set = 1'b0;
        ct = '0;
        // A group is ready once every member has been written
        ready = '1;
        for (int i = 0; i < NUM_CH; i++) begin
            c = ctrl_of(3'(i), grp);
            if (!pending_reg[i]) begin
                ready[c] = 1'b0;
            end
        end
        for (int i = 0; i < NUM_CH; i++) begin
            ct = ctrl_reg[i];
            // Source select: input A, input B, ground, supply
            case (ct[CT_SRC_LO +: 2])
                SRC_A: level[i] = a_s2_reg[i];
                SRC_B: level[i] = b_s2_reg[i];
                SRC_GND: level[i] = 1'b0;
                default: level[i] = 1'b1;
            endcase
            prev_lvl_next[i] = level[i];
            case (ct[CT_EDGE_LO +: 2])
                EDGE_RISE: trig = level[i] & ~prev_lvl_reg[i];
                EDGE_FALL: trig = ~level[i] & prev_lvl_reg[i];
                EDGE_BOTH: trig = level[i] ^ prev_lvl_reg[i];
                default: trig = 1'b0;
            endcase
            trig = trig & ct[CT_CAP_BIT];
            cap_dly_next[i] = trig & ct[CT_SYNC_BIT];
            cap = ct[CT_SYNC_BIT] ? cap_dly_reg[i] & ct[CT_CAP_BIT] :
                  trig;
            wr_ctl = wr_en && ch_hit && ch_idx == 3'(i) &&
                     !avs_address[CH_SEL_BIT];
            wr_val = wr_en && ch_hit && ch_idx == 3'(i) &&
                     avs_address[CH_SEL_BIT];
            // Control register; hardware set wins over software clear
            hw_set = cap | (~ct[CT_CAP_BIT] & match[i]);
            ctrl_next[i] = wr_ctl ? avs_writedata[CT_WIDTH-1:0] : ct;
            ctrl_next[i][CT_LEVEL_BIT] = 1'b0;
            ctrl_next[i][CT_FLAG_BIT] = hw_set |
                (wr_ctl ? avs_writedata[CT_FLAG_BIT] : ct[CT_FLAG_BIT]);
            ctrl_next[i][CT_OVF_BIT] = (cap & unread_reg[i]) |
                (ct[CT_OVF_BIT] & (~wr_ctl | avs_writedata[CT_OVF_BIT]));
            // Captured value and its unread marker
            value_next[i] = value_reg[i];
            if (cap) begin
                value_next[i] = count_reg;
            end else if (wr_val) begin
                value_next[i] = avs_writedata[CW-1:0];
            end
            unread_next[i] = cap | (unread_reg[i] & ~(rd_req && ch_hit &&
                             ch_idx == 3'(i) && avs_address[CH_SEL_BIT]));
            // Latch load timing, possibly taken from a group controller
            c = ctrl_of(3'(i), grp);
            grouped = (grp != GRP_NONE) &&
                      (ctrl_reg[c][CT_LLS_LO +: 2] != LLS_WRITE);
            j = grouped ? c : 3'(i);
            s = ctrl_reg[j][CT_LLS_LO +: 2];
            case (s)
                LLS_ZERO: evt = zero_evt;
                LLS_ZERO_PER: evt = zero_evt | (period_evt &&
                    gctrl_reg[GC_MODE_LO +: 2] == MODE_UPDOWN);
                LLS_OLD: evt = match[j];
                default: evt = 1'b0;
            endcase
            load = evt & (grouped ? ready[c] : pending_reg[i]);
            latch_next[i] = load ? value_reg[i] : latch_reg[i];
            pending_next[i] = wr_val | (pending_reg[i] & ~load);
            if (s == LLS_WRITE && wr_val) begin
                latch_next[i] = avs_writedata[CW-1:0];
                pending_next[i] = 1'b0;
            end
            // Output unit: channel action, then period action
            out_next[i] = out_reg[i];
            case (ct[CT_OM_LO +: 3])
                3'h0: out_next[i] = ctrl_next[i][CT_DRIVE_BIT];
                3'h1, 3'h3: if (match[i]) out_next[i] = 1'b1;
                3'h2, 3'h4, 3'h6:
                    if (match[i]) out_next[i] = ~out_reg[i];
                default: if (match[i]) out_next[i] = 1'b0;
            endcase
            if (period_evt && i != 0) begin
                case (ct[CT_OM_LO +: 3])
                    3'h2, 3'h3: out_next[i] = 1'b0;
                    3'h6, 3'h7: out_next[i] = 1'b1;
                    default: out_next[i] = out_next[i];
                endcase
            end
            oe_next[i] = ~(gctrl_reg[GC_HIZ_BIT] & hiz_s2_reg);
        end
    end

    // Read data, captured in the first cycle of a read
    always_comb begin
        logic [CT_WIDTH-1:0] rc;
        rc = ctrl_reg[ch_idx];
        readdata_next = readdata_reg;
        if (rd_req) begin
            readdata_next = '0;
            if (avs_address == GLOBAL_CTRL_OFS) begin
                readdata_next[5:0] = gctrl_reg;
            end else if (avs_address == COUNT_VALUE_OFS) begin
                readdata_next[CW-1:0] = count_reg;
            end else if (ch_hit && avs_address[CH_SEL_BIT]) begin
                readdata_next[CW-1:0] = value_reg[ch_idx];
            end else if (ch_hit && avs_address[2:0] == 3'h0) begin
                rc[CT_LEVEL_BIT] = level[ch_idx];
                readdata_next[CT_WIDTH-1:0] = rc;
            end
        end
    end

    // ======================================================================
    // Registers
    // Two-flop synchronisers for pins
    always_ff @(posedge clk) begin
        a_s1_reg <= channel_input_a;
        a_s2_reg <= a_s1_reg;
        b_s1_reg <= channel_input_b;
        b_s2_reg <= b_s1_reg;
        hiz_s1_reg <= output_hiz_pin;
        hiz_s2_reg <= hiz_s1_reg;
    end

    // All other state on the single clock, synchronous active-low reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            waitrequest_reg <= 1'b1;
            readdata_reg <= '0;
            gctrl_reg <= GC_RESET;
            count_reg <= '0;
            dir_up_reg <= 1'b1;
            pending_reg <= '0;
            unread_reg <= '0;
            prev_lvl_reg <= '0;
            cap_dly_reg <= '0;
            out_reg <= '0;
            oe_reg <= '1;
            for (int i = 0; i < NUM_CH; i++) begin
                ctrl_reg[i] <= CT_RESET;
                value_reg[i] <= '0;
                latch_reg[i] <= '0;
            end
        end else begin
            waitrequest_reg <= waitrequest_next;
            readdata_reg <= readdata_next;
            gctrl_reg <= gctrl_next;
            count_reg <= count_next;
            dir_up_reg <= dir_up_next;
            pending_reg <= pending_next;
            unread_reg <= unread_next;
            prev_lvl_reg <= prev_lvl_next;
            cap_dly_reg <= cap_dly_next;
            out_reg <= out_next;
            oe_reg <= oe_next;
            for (int i = 0; i < NUM_CH; i++) begin
                ctrl_reg[i] <= ctrl_next[i];
                value_reg[i] <= value_next[i];
                latch_reg[i] <= latch_next[i];
            end
        end
    end

    assign avs_waitrequest = waitrequest_reg;
    assign avs_readdata = readdata_reg;
    assign out_level = out_reg;
    assign out_oe = oe_reg;
endmodule
`default_nettype wire

// [testbench/cc_pin_partner.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Far side: capture sources, disable pin, output pins
module cc_pin_partner #(parameter int N = 7) (
    input wire logic clk,
    input wire logic [N-1:0] req_a,
    input wire logic [N-1:0] req_b,
    input wire logic req_hiz,
    input wire logic [N-1:0] out_level,
    input wire logic [N-1:0] out_oe,
    output var logic [N-1:0] channel_input_a,
    output var logic [N-1:0] channel_input_b,
    output var logic output_hiz_pin,
    output wire logic [N-1:0] pin_seen
);
    // Quiet levels before the first clock
    initial begin
        channel_input_a = '0;
        channel_input_b = '0;
        output_hiz_pin = 1'b0;
    end
    // Source levels move just after the rising edge
    always @(posedge clk) begin
        channel_input_a <= req_a;
        channel_input_b <= req_b;
        output_hiz_pin <= req_hiz;
    end
    // A pin floats when its driver is off
    for (genvar i = 0; i < N; i++) begin : g_pin
        assign pin_seen[i] = out_oe[i] ? out_level[i] : 1'bz;
    end
endmodule
`default_nettype wire

// [testbench/cc_unit_properties.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checker of the capture/compare unit
module cc_unit_properties
    import cc_unit_pkg::*;
#(parameter int NUM_CH = 7) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [NUM_CH-1:0] channel_input_a,
    input wire logic [NUM_CH-1:0] channel_input_b,
    input wire logic output_hiz_pin,
    input wire logic [NUM_CH-1:0] out_level,
    input wire logic [NUM_CH-1:0] out_oe
);
    wire logic rdone = avs_read && !avs_waitrequest;
    wire logic wdone = avs_write && !avs_waitrequest;
    logic hiz_en;
    logic drv0;
    logic [1:0] src0;
    logic [3:0] age;
    logic [3:0] stab;
    // Settings seen on the bus, cycles since a write or an edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hiz_en <= 1'b0;
            drv0 <= 1'b0;
            src0 <= 2'h0;
            age <= 4'h0;
            stab <= 4'h0;
        end else begin
            if (age != 4'hf) age <= age + 4'h1;
            if (stab != 4'hf) stab <= stab + 4'h1;
            if (wdone) age <= 4'h0;
            if ($changed(channel_input_a[0])) stab <= 4'h0;
            if (wdone && avs_address == GLOBAL_CTRL_OFS)
                hiz_en <= avs_writedata[GC_HIZ_BIT];
            if (wdone && avs_address == 8'h40) begin
                src0 <= avs_writedata[7:6];
                drv0 <= avs_writedata[CT_DRIVE_BIT];
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Assertions
    a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("access not answered");
    a_wait_back: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_unmapped_zero: assert property (rdone && avs_address == 8'hfc
        |-> avs_readdata == 32'h0000_0000) else $error("bad hole");
    a_hiz_float: assert property ((hiz_en && output_hiz_pin)[*5]
        |-> out_oe == '0) else $error("outputs still driven");
    a_hiz_drive: assert property ((!hiz_en || !output_hiz_pin)[*5]
        |-> out_oe == '1) else $error("outputs not driven");
    a_level_read: assert property (rdone && avs_address == 8'h40
        && src0 == SRC_A && stab > 4'h6 && age > 4'h6
        |-> avs_readdata[CT_LEVEL_BIT] == channel_input_a[0])
        else $error("input level wrong");
    a_level_fixed: assert property (rdone && avs_address == 8'h40
        && src0[1] && age > 4'h6 |-> avs_readdata[CT_LEVEL_BIT] == src0[0])
        else $error("fixed level wrong");
    a_mode0_drive: assert property (wdone && avs_address == 8'h40
        && avs_writedata[14:12] == 3'h0 |-> ##[1:3] out_level[0] == drv0)
        else $error("drive bit not shown");
    c_read: cover property (rdone);
    c_float: cover property (out_oe == '0);
    c_ctl0: cover property (wdone && avs_address == 8'h40);
endmodule
bind timer_capture_compare_unit cc_unit_properties #(.NUM_CH(NUM_CH)) u_prop (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .channel_input_a(channel_input_a),
    .channel_input_b(channel_input_b), .output_hiz_pin(output_hiz_pin),
    .out_level(out_level), .out_oe(out_oe));
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Self-checking bench of the capture/compare unit
module testbench;
    import cc_unit_pkg::*;
    localparam int N = 7;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [N-1:0] req_a = '0;
    logic [N-1:0] req_b = '0;
    logic req_hiz = 1'b0;
    wire logic [N-1:0] in_a, in_b, out_level, out_oe, pin_seen;
    wire logic hiz_pin;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [31:0] q;
    timer_capture_compare_unit #(.NUM_CH(N), .CW(16)) u_timer_capture_compare_unit (
        .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .channel_input_a(in_a),
        .channel_input_b(in_b), .output_hiz_pin(hiz_pin),
        .out_level(out_level), .out_oe(out_oe));
    cc_pin_partner #(.N(N)) u_cc_pin_partner (.clk(clk), .req_a(req_a),
        .req_b(req_b), .req_hiz(req_hiz), .out_level(out_level),
        .out_oe(out_oe), .channel_input_a(in_a), .channel_input_b(in_b),
        .output_hiz_pin(hiz_pin), .pin_seen(pin_seen));
    // Clock and hang guard
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fails++;
            give_verdict();
        end
    end
    // ==========================================================
    // Shared tasks
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        // Hold the request until waitrequest is sampled low at a rising edge
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(nm, q, e);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_regs();
        rd("global", GLOBAL_CTRL_OFS, 32'h0000_0000);
        rd("count", COUNT_VALUE_OFS, 32'h0000_0000);
        rd("ctl2", 8'h50, 32'h0000_0000);
        bus(1'b1, 8'hfc, 32'h0000_ffff);
        rd("hole", 8'hfc, 32'h0000_0000);
        bus(1'b1, 8'h48, 32'h0000_0040);
        req_b[1] <= 1'b1;
        idle(8);
        rd("ctl1 b", 8'h48, 32'h0000_0048);
        req_b[1] <= 1'b0;
    endtask
    task automatic t_capture();
        bus(1'b1, 8'h48, 32'h0000_0130);
        bus(1'b1, COUNT_VALUE_OFS, 32'h0000_1234);
        req_a[1] <= 1'b1;
        idle(8);
        rd("val1 rise", 8'h4c, 32'h0000_1234);
        bus(1'b1, 8'h48, 32'h0000_0130);
        bus(1'b1, COUNT_VALUE_OFS, 32'h0000_2222);
        req_a[1] <= 1'b0;
        idle(8);
        rd("ctl1 fall", 8'h48, 32'h0000_0130);
        bus(1'b1, 8'h48, 32'h0000_0330);
        req_a[1] <= 1'b1;
        idle(8);
        bus(1'b1, COUNT_VALUE_OFS, 32'h0000_3333);
        req_a[1] <= 1'b0;
        idle(8);
        rd("val1 both", 8'h4c, 32'h0000_3333);
        rd("ctl1 ovf", 8'h48, 32'h0000_0333);
        bus(1'b1, 8'h48, 32'h0000_0330);
        rd("ctl1 clr", 8'h48, 32'h0000_0330);
    endtask
    task automatic t_soft();
        bus(1'b1, COUNT_VALUE_OFS, 32'h0000_0055);
        bus(1'b1, 8'h40, 32'h0000_0390);
        idle(8);
        bus(1'b1, 8'h40, 32'h0000_03d0);
        idle(8);
        rd("val0 vcc", 8'h44, 32'h0000_0055);
        rd("ctl0 vcc", 8'h40, 32'h0000_03d9);
        bus(1'b1, COUNT_VALUE_OFS, 32'h0000_0066);
        bus(1'b1, 8'h40, 32'h0000_0390);
        idle(8);
        rd("val0 gnd", 8'h44, 32'h0000_0066);
        rd("ctl0 gnd", 8'h40, 32'h0000_0391);
    endtask
    task automatic t_compare();
        int k;
        k = 0;
        bus(1'b1, 8'h40, 32'h0000_0000);
        bus(1'b1, 8'h44, 32'h0000_0009);
        bus(1'b1, 8'h48, 32'h0000_1000);
        bus(1'b1, 8'h4c, 32'h0000_0004);
        bus(1'b1, COUNT_VALUE_OFS, 32'h0000_0000);
        bus(1'b1, GLOBAL_CTRL_OFS, {30'h0, MODE_UP});
        while (out_level[1] !== 1'b1 && k < 40) begin
            @(negedge clk);
            k++;
        end
        chk("out1 set", {31'h0, out_level[1]}, 32'h0000_0001);
        bus(1'b1, GLOBAL_CTRL_OFS, 32'h0000_0000);
        rd("ctl1 match", 8'h48, 32'h0000_1001);
    endtask
    task automatic t_pins();
        bus(1'b1, 8'h58, 32'h0000_0004);
        idle(4);
        chk("out3 drive", {31'h0, out_level[3]}, 32'h0000_0001);
        bus(1'b1, GLOBAL_CTRL_OFS, 32'h0000_0010);
        req_hiz <= 1'b1;
        idle(8);
        chk("oe float", {25'h0, out_oe}, 32'h0000_0000);
        chk("pin3", {31'h0, pin_seen[3]}, {31'h0, 1'bz});
        bus(1'b1, GLOBAL_CTRL_OFS, 32'h0000_0000);
        idle(8);
        chk("oe off", {25'h0, out_oe}, 32'h0000_007f);
        req_hiz <= 1'b0;
    endtask
    // Main sequence
    initial begin
        idle(20);
        rst_n <= 1'b1;
        t_regs();
        t_capture();
        t_soft();
        t_compare();
        t_pins();
        give_verdict();
    end
endmodule
`default_nettype wire
